// ==== src/nsa_top.sv ====
// nsa_top: wishbone register file for direct and word-read nvm access
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
// Functional notes
// - auto update runs only when enable set
// - sector bit shows which sector is valid
// - sector bit zero for eeprom or absent
// - kind bit read only, from word 0x0F
// - serial output sampled into bit 3
// - start launches one word read, self-clears
// - done resets high, low while busy
// - address field selects the fetched word
// - fetched word appears in bits 31:16
// - fetched word never loads internal registers
// - request bit, wait grant, then clear request
// - present bit reflects attached signed nvm
module nsa_top
  import nsa_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        linkClk,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             nvmSerialClock,
  output logic             nvmChipSelect,
  output logic             nvmSerialIn,
  input  wire logic        nvmSerialOut,
  input  wire logic        nvmPresent,
  input  wire logic        nvmStrapFlash,
  input  wire logic        sectorOneValid,
  input  wire logic        nvmKindLoaded,
  input  wire logic        flashWriteCycle,
  input  wire logic        flashUpdateTimer,
  output logic             autoFlashUpdateEn,
  output logic             autoFlashUpdateGo,
  output logic      [1:0]  flashWriteCtrl
);
  nsa_link_if lnk ();

  logic        ack_r;
  logic [31:0] rdat_r;
  logic        busReq;
  logic        wrDirect;
  logic        wrWord;
  logic [31:0] directNew;
  logic [31:0] wordNew;
  logic        skBit_r;
  logic        csBit_r;
  logic        diBit_r;
  logic [1:0]  fwe_r;
  logic        req_r;
  logic        grant_r;
  logic        aupd_r;
  logic        goPulse_r;
  logic [1:0]  doSync_r;
  logic        nvmDo_r;
  logic        done_r;
  logic        startTgl_r;
  logic [13:0] addr_r;
  logic [13:0] launchAddr_r;
  logic [15:0] data_r;
  logic [2:0]  doneSync_r;
  logic        doneEdge;
  logic        startReq;
  logic        sectorBit;
  logic [31:0] directView;
  logic [31:0] wordView;

  // ==========================================================
  // wishbone slave decode
  assign busReq    = wb_cyc_i && wb_stb_i && !ack_r;
  assign wrDirect  = busReq && wb_we_i && (wb_adr_i == NSA_OFF_DIRECT);
  assign wrWord    = busReq && wb_we_i && (wb_adr_i == NSA_OFF_WORDRD);
  assign directNew = nsaMerge(directView, wb_dat_i, wb_sel_i);
  assign wordNew   = nsaMerge(wordView, wb_dat_i, wb_sel_i);

  // ack comes one cycle after the request, then ack drops for a cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq;
    end
  end

  // unmapped offsets read as zero and still complete
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdat_r <= 32'h00000000;
    end else if (busReq) begin
      unique case (wb_adr_i)
        NSA_OFF_DIRECT: rdat_r <= directView;
        NSA_OFF_WORDRD: rdat_r <= wordView;
        default:        rdat_r <= 32'h00000000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ==========================================================
  // direct access control bits
  // software sequences the serial frame itself through these bits
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      skBit_r <= 1'b0;
      csBit_r <= 1'b0;
      diBit_r <= 1'b0;
    end else if (wrDirect) begin
      skBit_r <= directNew[NSA_B_SK];
      csBit_r <= directNew[NSA_B_CS];
      diBit_r <= directNew[NSA_B_DI];
    end
  end

  // write control is only stored; misuse of 01 is the caller's problem
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fwe_r <= NSA_FWE_RST;
    end else if (wrDirect) begin
      fwe_r <= directNew[NSA_B_FWE +: 2];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      req_r <= 1'b0;
    end else if (wrDirect) begin
      req_r <= directNew[NSA_B_REQ];
    end
  end

  // grant waits for an idle engine so a frame is never cut
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      grant_r <= 1'b0;
    end else if (!req_r) begin
      grant_r <= 1'b0;
    end else if (done_r && !startReq) begin
      grant_r <= 1'b1;
    end
  end

  // ==========================================================
  // autonomous flash update gate
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      aupd_r <= 1'b0;
    end else if (wrDirect) begin
      aupd_r <= directNew[NSA_B_AUPD];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      goPulse_r <= 1'b0;
    end else begin
      goPulse_r <= aupd_r && (flashWriteCycle || flashUpdateTimer);
    end
  end

  assign autoFlashUpdateEn = aupd_r;
  assign autoFlashUpdateGo = goPulse_r;
  assign flashWriteCtrl    = fwe_r;

  // ==========================================================
  // serial output capture for software read-back
  // two flops because the pin belongs to the nvm, not to mclk
  always_ff @(posedge mclk) begin
    doSync_r <= {doSync_r[0], nvmSerialOut};
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nvmDo_r <= 1'b0;
    end else begin
      nvmDo_r <= doSync_r[1];
    end
  end

  // ==========================================================
  // word read request and completion
  assign startReq = wrWord && wordNew[NSA_B_START] && done_r && !grant_r;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      addr_r <= 14'h0000;
    end else if (wrWord && done_r) begin
      addr_r <= wordNew[NSA_B_ADDR_HI:NSA_B_ADDR_LO];
    end
  end

  // launch copy stays frozen across the crossing
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      launchAddr_r <= 14'h0000;
      startTgl_r   <= 1'b0;
    end else if (startReq) begin
      launchAddr_r <= wordNew[NSA_B_ADDR_HI:NSA_B_ADDR_LO];
      startTgl_r   <= ~startTgl_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      doneSync_r <= 3'h0;
    end else begin
      doneSync_r <= {doneSync_r[1:0], lnk.doneTgl};
    end
  end
  assign doneEdge = doneSync_r[2] != doneSync_r[1];

  // start itself is never stored, so it reads back as zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      done_r <= NSA_DONE_RST;
    end else if (startReq) begin
      done_r <= 1'b0;
    end else if (doneEdge) begin
      done_r <= 1'b1;
    end
  end

  // word goes only to this field, no other register loads it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      data_r <= 16'h0000;
    end else if (doneEdge) begin
      data_r <= lnk.word;
    end
  end

  // ==========================================================
  // read views
  assign sectorBit = nvmPresent && nvmStrapFlash && sectorOneValid;

  always_comb begin
    directView                 = 32'h00000000;
    directView[NSA_B_SK]       = skBit_r;
    directView[NSA_B_CS]       = csBit_r;
    directView[NSA_B_DI]       = diBit_r;
    directView[NSA_B_DO]       = nvmDo_r;
    directView[NSA_B_FWE +: 2] = fwe_r;
    directView[NSA_B_REQ]      = req_r;
    directView[NSA_B_GNT]      = grant_r;
    directView[NSA_B_PRES]     = nvmPresent;
    directView[NSA_B_AUPD]     = aupd_r;
    directView[NSA_B_SEC1]     = sectorBit;
    directView[NSA_B_KIND]     = nvmKindLoaded;
  end

  always_comb begin
    wordView                                = 32'h00000000;
    wordView[NSA_B_DONE]                    = done_r;
    wordView[NSA_B_ADDR_HI:NSA_B_ADDR_LO]   = addr_r;
    wordView[31:NSA_B_DATA_LO]              = data_r;
  end

  // ==========================================================
  // link domain
  assign lnk.startTgl = startTgl_r;
  assign lnk.wordAddr = launchAddr_r;
  assign lnk.grantOn  = grant_r;
  assign lnk.skBit    = skBit_r;
  assign lnk.csBit    = csBit_r;
  assign lnk.diBit    = diBit_r;

  nsa_serial_engine u_engine (
    .linkClk        (linkClk),
    .rst_b          (rst_b),
    .lnk            (lnk),
    .nvmSerialClock (nvmSerialClock),
    .nvmChipSelect  (nvmChipSelect),
    .nvmSerialIn    (nvmSerialIn),
    .nvmSerialOut   (nvmSerialOut)
  );
endmodule // nsa_top

// ==== shared/nsa_pkg.sv ====
// nsa_pkg: register map, field positions and serial constants of the nvm access block
package nsa_pkg;
  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] NSA_OFF_DIRECT = 8'h10;
  localparam logic [7:0] NSA_OFF_WORDRD = 8'h14;
  // ==========================================================
  // direct control field positions
  localparam int NSA_B_SK   = 0;
  localparam int NSA_B_CS   = 1;
  localparam int NSA_B_DI   = 2;
  localparam int NSA_B_DO   = 3;
  localparam int NSA_B_FWE  = 4;
  localparam int NSA_B_REQ  = 6;
  localparam int NSA_B_GNT  = 7;
  localparam int NSA_B_PRES = 8;
  localparam int NSA_B_AUPD = 20;
  localparam int NSA_B_SEC1 = 22;
  localparam int NSA_B_KIND = 23;
  // ==========================================================
  // word read field positions
  localparam int NSA_B_START   = 0;
  localparam int NSA_B_DONE    = 1;
  localparam int NSA_B_ADDR_LO = 2;
  localparam int NSA_B_ADDR_HI = 15;
  localparam int NSA_B_DATA_LO = 16;
  // ==========================================================
  // values after reset
  localparam logic [1:0] NSA_FWE_RST  = 2'h1;
  localparam logic       NSA_DONE_RST = 1'h1;
  // ==========================================================
  // serial read command and frame sizes, counted in bits
  localparam logic [7:0] NSA_OP_READ    = 8'h03;
  localparam int         NSA_CMD_BITS   = 8;
  localparam int         NSA_ADDR_BITS  = 16;
  localparam int         NSA_DATA_BITS  = 16;
  localparam int         NSA_FRAME_BITS = NSA_CMD_BITS + NSA_ADDR_BITS + NSA_DATA_BITS;
  localparam logic [1:0] NSA_PH_SAMPLE  = 2'h3;

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] nsaMerge(input logic [31:0] old, input logic [31:0] wr,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[8*i +: 8] = wr[8*i +: 8];
    end
    return res;
  endfunction
endpackage

// ==== shared/nsa_link_if.sv ====
// nsa_link_if: signals between the register side and the link-clock serial engine
`timescale 1ns/1ps
interface nsa_link_if;
  logic        startTgl;
  logic [13:0] wordAddr;
  logic        doneTgl;
  logic [15:0] word;
  logic        grantOn;
  logic        skBit;
  logic        csBit;
  logic        diBit;
  modport regs (output startTgl, wordAddr, grantOn, skBit, csBit, diBit, input doneTgl, word);
  modport eng  (input startTgl, wordAddr, grantOn, skBit, csBit, diBit, output doneTgl, word);
endinterface

// ==== src/nsa_serial_engine.sv ====
// nsa_serial_engine: link-clock serial word fetch and direct pin mapping
`timescale 1ns/1ps
module nsa_serial_engine
  import nsa_pkg::*;
(
  input  wire logic linkClk,
  input  wire logic rst_b,
  nsa_link_if.eng   lnk,
  output logic      nvmSerialClock,
  output logic      nvmChipSelect,
  output logic      nvmSerialIn,
  input  wire logic nvmSerialOut
);
  typedef enum logic [1:0] {NSA_IDLE, NSA_SHIFT, NSA_FINISH} nsa_state_t;
  nsa_state_t  state_r;
  logic [1:0]  rstSync_r;
  logic        lrst_b;
  logic [2:0]  startSync_r;
  logic [3:0]  dirSync0_r;
  logic [3:0]  dirSync1_r;
  logic [1:0]  doSync_r;
  logic [1:0]  phase_r;
  logic [5:0]  bitCnt_r;
  logic [23:0] outSh_r;
  logic [15:0] inSh_r;
  logic        sk_r;
  logic        cs_r;
  logic        doneTgl_r;
  logic [15:0] word_r;

  // ==========================================================
  // crossings into the link domain
  always_ff @(posedge linkClk) begin
    rstSync_r <= {rstSync_r[0], rst_b};
  end
  assign lrst_b = rstSync_r[1];

  always_ff @(posedge linkClk) begin
    startSync_r <= {startSync_r[1:0], lnk.startTgl};
    dirSync0_r  <= {lnk.grantOn, lnk.skBit, lnk.csBit, lnk.diBit};
    dirSync1_r  <= dirSync0_r;
    doSync_r    <= {doSync_r[0], nvmSerialOut};
  end

  // ==========================================================
  // read frame: command, byte address, then two data bytes
  always_ff @(posedge linkClk) begin
    if (!lrst_b) begin
      state_r   <= NSA_IDLE;
      phase_r   <= 2'h0;
      bitCnt_r  <= 6'h00;
      outSh_r   <= 24'h000000;
      inSh_r    <= 16'h0000;
      sk_r      <= 1'b0;
      cs_r      <= 1'b0;
      doneTgl_r <= 1'b0;
      word_r    <= 16'h0000;
    end else begin
      unique case (state_r)
        NSA_IDLE: if (startSync_r[2] != startSync_r[1]) begin
          state_r  <= NSA_SHIFT;
          cs_r     <= 1'b1;
          phase_r  <= 2'h0;
          bitCnt_r <= 6'h00;
          // byte address is twice the word address
          outSh_r  <= {NSA_OP_READ, 1'b0, lnk.wordAddr, 1'b0};
        end
        NSA_SHIFT: begin
          phase_r <= phase_r + 2'h1;
          sk_r    <= (phase_r == 2'h0) || (phase_r == 2'h1);
          if (phase_r == NSA_PH_SAMPLE) begin
            // synced value reflects the pin during the high phase
            inSh_r   <= {inSh_r[14:0], doSync_r[1]};
            outSh_r  <= {outSh_r[22:0], 1'b0};
            bitCnt_r <= bitCnt_r + 6'h01;
            if (bitCnt_r == 6'(NSA_FRAME_BITS - 1)) state_r <= NSA_FINISH;
          end
        end
        NSA_FINISH: begin
          state_r   <= NSA_IDLE;
          cs_r      <= 1'b0;
          word_r    <= {inSh_r[7:0], inSh_r[15:8]};
          doneTgl_r <= ~doneTgl_r;
        end
      endcase
    end
  end

  assign lnk.doneTgl    = doneTgl_r;
  assign lnk.word       = word_r;
  // direct bits own the pins only while granted and idle
  assign nvmSerialClock = dirSync1_r[3] ? dirSync1_r[2] : sk_r;
  assign nvmChipSelect  = dirSync1_r[3] ? dirSync1_r[1] : cs_r;
  assign nvmSerialIn    = dirSync1_r[3] ? dirSync1_r[0] : outSh_r[23];
endmodule // nsa_serial_engine

// ==== verification/nsa_nvm_model.sv ====
// nsa_nvm_model: behavioural serial nvm answering the word read command
`timescale 1ns/1ps
module nsa_nvm_model (
  input  wire logic sk,
  input  wire logic cs,
  input  wire logic di,
  output logic      dout
);
  // ==========================================================
  // command and address capture
  int          cnt;
  logic [23:0] cmdAddr;
  logic [15:0] ba;
  logic [15:0] stream;
  function automatic logic [7:0] bv(input logic [15:0] b);
    return b[7:0] ^ b[15:8] ^ 8'hA5;
  endfunction
  initial dout = 1'h0;
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      cnt <= 0;
    end else begin
      if (cnt < 24) cmdAddr <= {cmdAddr[22:0], di};
      cnt <= cnt + 1;
    end
  end
  assign ba     = cmdAddr[15:0];
  assign stream = {bv(ba), bv(ba + 16'h1)};
  // ==========================================================
  // data out on falling clock; outside a read frame the line toggles so no stale bit passes
  always @(negedge sk or negedge cs) begin
    if (!cs || cnt < 24 || cnt > 39 || cmdAddr[23:16] !== 8'h03) dout <= ~dout;
    else dout <= stream[39 - cnt];
  end
endmodule // nsa_nvm_model

// ==== verification/nsa_top_props.sv ====
// nsa_top_props: port-level assertions for the nvm access block
`timescale 1ns/1ps
module nsa_top_props
  import nsa_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        linkClk,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        nvmSerialClock,
  input wire logic        nvmChipSelect,
  input wire logic        nvmSerialIn,
  input wire logic        nvmSerialOut,
  input wire logic        nvmPresent,
  input wire logic        nvmStrapFlash,
  input wire logic        sectorOneValid,
  input wire logic        nvmKindLoaded,
  input wire logic        flashWriteCycle,
  input wire logic        flashUpdateTimer,
  input wire logic        autoFlashUpdateEn,
  input wire logic        autoFlashUpdateGo,
  input wire logic [1:0]  flashWriteCtrl
);
  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic rdDir;
  logic rdWrd;
  assign rdDir = wb_ack_o && !wb_we_i && wb_adr_i == NSA_OFF_DIRECT;
  assign rdWrd = wb_ack_o && !wb_we_i && wb_adr_i == NSA_OFF_WORDRD;
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_go_cause; autoFlashUpdateGo |-> $past(autoFlashUpdateEn) && ($past(flashWriteCycle) || $past(flashUpdateTimer)); endproperty
  a_go_cause: assert property (p_go_cause) else $error("update pulse without enabled trigger");
  property p_go_fire; autoFlashUpdateEn && (flashWriteCycle || flashUpdateTimer) |=> autoFlashUpdateGo; endproperty
  a_go_fire: assert property (p_go_fire) else $error("enabled trigger gave no update pulse");
  property p_sec_set; rdDir && $past(nvmPresent) && $past(nvmStrapFlash) && $past(sectorOneValid) |-> wb_dat_o[NSA_B_SEC1]; endproperty
  a_sec_set: assert property (p_sec_set) else $error("upper sector bit not shown");
  property p_sec_zero; rdDir && !($past(nvmPresent) && $past(nvmStrapFlash)) |-> !wb_dat_o[NSA_B_SEC1]; endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("sector bit set without flash");
  property p_kind; rdDir |-> wb_dat_o[NSA_B_KIND] == $past(nvmKindLoaded); endproperty
  a_kind: assert property (p_kind) else $error("kind bit wrong");
  property p_pres; rdDir |-> wb_dat_o[NSA_B_PRES] == $past(nvmPresent); endproperty
  a_pres: assert property (p_pres) else $error("present bit wrong");
  property p_start_clr; rdWrd |-> !wb_dat_o[NSA_B_START]; endproperty
  a_start_clr: assert property (p_start_clr) else $error("start bit reads set");
  property p_fwe_rst; $rose(rst_b) |-> flashWriteCtrl == NSA_FWE_RST; endproperty
  a_fwe_rst: assert property (p_fwe_rst) else $error("write control not 01 after reset");
endmodule // nsa_top_props
bind nsa_top nsa_top_props nsa_top_props_inst (.*);

// ==== verification/tb_top.sv ====
// tb_top: register-level bench for the nvm access block
`timescale 1ns/1ps
module tb_top
  import nsa_pkg::*;
;
  // ==========================================================
  // signals
  logic        mclk, rst_b, linkClk, wbCyc, wbStb, wbWe, wbAck;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDat, wbDatO, rd, ex;
  logic        sk, cs, di, so, pres, strap, sec1, kind, wcyc, tmr, aEn, aGo;
  logic [1:0]  flash_write_ctrl;
  int          bad_count, n_checks, i, j;
  logic [13:0] addrs[4] = '{14'h0000, 14'h000F, 14'h1234, 14'h3FFF};
  logic [31:0] dirSeq[4] = '{32'h0000_0056, 32'h0000_0057, 32'h0000_0052, 32'h0000_0050};
  nsa_top nsa_top_inst (.mclk(mclk), .rst_b(rst_b), .linkClk(linkClk), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .nvmSerialClock(sk), .nvmChipSelect(cs), .nvmSerialIn(di), .nvmSerialOut(so), .nvmPresent(pres),
    .nvmStrapFlash(strap), .sectorOneValid(sec1), .nvmKindLoaded(kind), .flashWriteCycle(wcyc),
    .flashUpdateTimer(tmr), .autoFlashUpdateEn(aEn), .autoFlashUpdateGo(aGo), .flashWriteCtrl(flash_write_ctrl));
  nsa_nvm_model nsa_nvm_model_inst (.sk(sk), .cs(cs), .di(di), .dout(so));
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'h0;
    #7;
    forever #62.5 linkClk = ~linkClk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] expWord(input logic [13:0] a);
    logic [15:0] b;
    logic [15:0] c;
    b = {1'h0, a, 1'h0};
    c = b + 16'h0001;
    return {c[7:0] ^ c[15:8] ^ 8'hA5, b[7:0] ^ b[15:8] ^ 8'hA5, a, 2'h2};
  endfunction
  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDat, wbSel} <= {2'h3, w, a, d, 4'hF};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wbAck !== 1'h1 && k < 50);
    rd = wbDatO;
    {wbCyc, wbStb} <= 2'h0;
    if (k >= 50) begin
      bad_count++;
      final_report();
    end
  endtask
  // ==========================================================
  // sequence
  initial begin
    {rst_b, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDat, pres, strap, sec1, kind, wcyc, tmr} = '0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (20) @(posedge mclk);
    wbAcc(1'h0, NSA_OFF_WORDRD, 32'h0);
    chk("wordrd reset", 32'h0000_0002, rd);
    wbAcc(1'h0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (j = 0; j < 16; j++) begin
      {pres, strap, sec1, kind} <= j[3:0];
      wbAcc(1'h0, NSA_OFF_DIRECT, 32'h0);
      ex = {j[0], &j[3:1], 13'h0, j[3], 2'h0, 2'h1, 4'h0};
      chk("status", ex, rd & 32'h00C0_0130);
    end
    for (j = 1; j >= 0; j--) begin
      wbAcc(1'h1, NSA_OFF_DIRECT, {11'h0, j[0], 20'h10});
      {wcyc, tmr} <= {j[0], !j[0]};
      @(posedge mclk);
      {wcyc, tmr} <= 2'h0;
      @(posedge mclk);
      chk("autogo", {31'h0, j[0]}, {31'h0, aGo});
    end
    foreach (addrs[n]) begin
      wbAcc(1'h1, NSA_OFF_WORDRD, {16'h0, addrs[n], 2'h1});
      wbAcc(1'h0, NSA_OFF_WORDRD, 32'h0);
      chk("busy", 32'h0, rd & 32'h3);
      wbAcc(1'h1, NSA_OFF_WORDRD, {16'h0, addrs[n] + 14'h1, 2'h1});
      for (i = 0; i < 1000 && rd[1] !== 1'h1; i++) wbAcc(1'h0, NSA_OFF_WORDRD, 32'h0);
      chk("word", expWord(addrs[n]), rd);
    end
    wbAcc(1'h1, NSA_OFF_DIRECT, 32'h50);
    for (i = 0; i < 20 && rd[7] !== 1'h1; i++) wbAcc(1'h0, NSA_OFF_DIRECT, 32'h0);
    chk("grant", 32'h80, rd & 32'h80);
    wbAcc(1'h1, NSA_OFF_WORDRD, 32'h15);
    wbAcc(1'h0, NSA_OFF_WORDRD, 32'h0);
    chk("start granted", 32'h2, rd & 32'h3);
    foreach (dirSeq[n]) begin
      wbAcc(1'h1, NSA_OFF_DIRECT, dirSeq[n]);
      repeat (40) @(posedge mclk);
      chk("pins", dirSeq[n] & 32'h7, {29'h0, di, cs, sk});
      wbAcc(1'h0, NSA_OFF_DIRECT, 32'h0);
      chk("serial out", {28'h0, so, 3'h0}, rd & 32'h8);
    end
    wbAcc(1'h1, NSA_OFF_DIRECT, 32'h10);
    repeat (4) @(posedge mclk);
    wbAcc(1'h0, NSA_OFF_DIRECT, 32'h0);
    chk("grant off", 32'h0, rd & 32'hC0);
    final_report();
  end
endmodule // tb_top
